// [verilog/iocpc_pkg.sv]
// shared constants and types of the coherency agent event counter block
package iocpc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int CTR_W  = 48;
   localparam int INC_W  = 7;
   localparam int OCC_W  = 7;
   localparam int WC_W   = 6;
   localparam int NCLS   = 3;
   localparam int NSRC   = 3;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFS_CTL0    = 8'h00;
   localparam logic [7:0] OFS_CTL1    = 8'h04;
   localparam logic [7:0] OFS_CTR0_LO = 8'h08;
   localparam logic [7:0] OFS_CTR0_HI = 8'h0c;
   localparam logic [7:0] OFS_CTR1_LO = 8'h10;
   localparam logic [7:0] OFS_CTR1_HI = 8'h14;
   localparam logic [7:0] OFS_STATUS  = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // control word fields
   localparam int          CTL_EV_LSB  = 0;
   localparam int          CTL_UM_LSB  = 8;
   localparam int          CTL_CLR_BIT = 17;
   localparam int          CTL_EN_BIT  = 22;
   localparam logic [31:0] CTL_RW_MASK = 32'h0040ffff;
   localparam logic [31:0] CTL_RST     = 32'h00000000;
   localparam logic [1:0]  WRAP_RST    = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // event codes
   localparam logic [7:0] EV_CYCLE    = 8'h01;
   localparam logic [7:0] EV_DR_INS   = 8'h02;
   localparam logic [7:0] EV_DR_FULL  = 8'h05;
   localparam logic [7:0] EV_DR_OCC   = 8'h08;
   localparam logic [7:0] EV_ACK      = 8'h0b;
   localparam logic [7:0] EV_OUTREQ   = 8'h0c;
   localparam logic [7:0] EV_WC_OCC   = 8'h0f;
   localparam logic [7:0] EV_FAF_SENT = 8'h16;
   localparam logic [7:0] EV_FAF_FULL = 8'h17;
   localparam logic [7:0] EV_FAF_INS  = 8'h18;
   localparam logic [7:0] EV_FAF_OCC  = 8'h19;
   localparam logic [7:0] EV_AD_STALL = 8'h1a;
   localparam logic [7:0] EV_DR_STALL = 8'h1b;

   // write cache source masks and indices
   localparam logic [7:0] UM_ANY   = 8'h01;
   localparam logic [7:0] UM_SNOOP = 8'h02;
   localparam logic [7:0] UM_MEM   = 8'h04;
   localparam int         SRC_ANY   = 0;
   localparam int         SRC_SNOOP = 1;
   localparam int         SRC_MEM   = 2;

   // ring message class index: response, bypass, standard
   localparam int CLS_RESP   = 0;
   localparam int CLS_BYPASS = 1;
   localparam int CLS_STD    = 2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [NCLS-1:0]            dr_insert;
      logic [NCLS-1:0]            dr_full;
      logic [NCLS-1:0][OCC_W-1:0] dr_occ;
      logic                       ack_alloc;
      logic [OCC_W-1:0]           outreq_occ;
      logic [NSRC-1:0][WC_W-1:0]  wc_rd_occ;
      logic [NSRC-1:0][WC_W-1:0]  wc_wr_occ;
      logic                       ad_stall;
      logic                       dr_stall;
      logic                       faf_sent;
      logic                       faf_full;
      logic                       faf_insert;
      logic [OCC_W-1:0]           faf_occ;
   } iocpc_events_t;

   typedef struct packed {
      logic [31:0] ctl0;
      logic [31:0] ctl1;
      logic [1:0]  wrap;
      logic        wr_pend;
      logic [7:0]  wr_ofs;
      logic [31:0] rdata;
   } iocpc_regs_t;

endpackage

// [verilog/iocpc_event_sel.sv]
// per-cycle event amount selected by event code and unit mask
`timescale 1ns/1ps
module iocpc_event_sel (
   // selection
   input  wire logic [7:0]                 code_i,
   input  wire logic [7:0]                 umask_i,
   // agent events
   input  wire iocpc_pkg::iocpc_events_t   ev_i,
   // amount
   output logic      [iocpc_pkg::INC_W-1:0] inc_o
);

   function automatic logic [iocpc_pkg::INC_W-1:0] amount(input logic [7:0] code,
                                                          input logic [7:0] um,
                                                          input iocpc_pkg::iocpc_events_t ev);
      logic [iocpc_pkg::INC_W-1:0] a;
      int                          s;
      a = '0;
      s = -1;
      for (int c = 0; c < iocpc_pkg::NCLS; c++) begin
         if (code == iocpc_pkg::EV_DR_INS + 8'(c))
            a = 7'(ev.dr_insert[c]);
         if (code == iocpc_pkg::EV_DR_FULL + 8'(c))
            a = 7'(ev.dr_full[c]);
         if (code == iocpc_pkg::EV_DR_OCC + 8'(c))
            a = ev.dr_occ[c];
      end
      unique case (um)
         iocpc_pkg::UM_ANY:   s = iocpc_pkg::SRC_ANY;
         iocpc_pkg::UM_SNOOP: s = iocpc_pkg::SRC_SNOOP;
         iocpc_pkg::UM_MEM:   s = iocpc_pkg::SRC_MEM;
         default:             s = -1;
      endcase
      case (code)
         iocpc_pkg::EV_CYCLE:    a = 7'h01;
         iocpc_pkg::EV_ACK:      a = 7'(ev.ack_alloc);
         iocpc_pkg::EV_OUTREQ:   a = ev.outreq_occ;
         iocpc_pkg::EV_WC_OCC: begin
            if (s >= 0)
               a = 7'(ev.wc_rd_occ[s]) + 7'(ev.wc_wr_occ[s]);
         end
         iocpc_pkg::EV_FAF_SENT: a = 7'(ev.faf_sent);
         iocpc_pkg::EV_FAF_FULL: a = 7'(ev.faf_full);
         iocpc_pkg::EV_FAF_INS:  a = 7'(ev.faf_insert);
         iocpc_pkg::EV_FAF_OCC:  a = ev.faf_occ;
         iocpc_pkg::EV_AD_STALL: a = 7'(ev.ad_stall);
         iocpc_pkg::EV_DR_STALL: a = 7'(ev.dr_stall);
         default: ;
      endcase
      return a;
   endfunction

   assign inc_o = amount(code_i, umask_i, ev_i);

endmodule

// [verilog/iocpc_counter.sv]
// one wide event counter with clear, preset and wrap pulse
`timescale 1ns/1ps
module iocpc_counter #(
   parameter int CTR_W = 48,
   parameter int INC_W = 7
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // counting
   input  wire logic              en_i,
   input  wire logic [INC_W-1:0]  inc_i,
   // software access
   input  wire logic              clear_i,
   input  wire logic              load_lo_i,
   input  wire logic              load_hi_i,
   input  wire logic [31:0]       wdata_i,
   // state
   output logic      [CTR_W-1:0]  count_o,
   output logic                   wrap_o
);

   typedef struct packed {
      logic [CTR_W-1:0] count;
   } iocpc_cnt_t;

   iocpc_cnt_t       r;
   iocpc_cnt_t       next_r;
   logic [CTR_W:0]   sum;
   logic             sw;

   if (CTR_W < 33 || CTR_W > 64 || INC_W < 1 || INC_W >= CTR_W)
      $error("iocpc_counter: unsupported width");

   assign sum = {1'b0, r.count} + (CTR_W+1)'(inc_i);
   assign sw  = clear_i | load_lo_i | load_hi_i;

   always_comb begin
      next_r = r;
      if (clear_i)
         next_r.count = '0;
      else if (load_lo_i)
         next_r.count[31:0] = wdata_i;
      else if (load_hi_i)
         next_r.count[CTR_W-1:32] = wdata_i[CTR_W-33:0];
      else if (en_i)
         next_r.count = sum[CTR_W-1:0];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         r <= '0;
      else
         r <= next_r;
   end

   assign count_o = r.count;
   assign wrap_o  = en_i & ~sw & sum[CTR_W];

endmodule

// [verilog/iocpc_top.sv]
// coherency agent event counters with an AHB-Lite register slave
// Function
// - two 48-bit counters, each may count any agent event
// - each cycle a counter adds the full amount, up to seven bits
// - code 0x0f adds outstanding reads plus writes every cycle
// - for 0x0f mask 01 any source, 02 snoops, 04 memory
// - codes 0x02-0x04 data ring inserts per class, 0x0b acknowledge allocations
// - codes 0x05-0x07 count data ring egress full cycles per class
// - codes 0x08-0x0a add data ring egress occupancy per class
// - code 0x0c adds outbound request queue occupancy
// - 0x1a address ring credit stalls, 0x1b data ring credit stalls
// - 0x16 sent, 0x17 full, 0x18 inserts, 0x19 occupancy of forward queue
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module iocpc_top #(
   parameter int CTR_W = 48,
   parameter int INC_W = 7
) (
   // clock and reset
   input  wire logic                      REF_CLK_I,
   input  wire logic                      RESET_I,
   // AHB-Lite slave
   input  wire logic                      HSEL_I,
   input  wire logic [31:0]               HADDR_I,
   input  wire logic [1:0]                HTRANS_I,
   input  wire logic                      HWRITE_I,
   input  wire logic [2:0]                HSIZE_I,
   input  wire logic [31:0]               HWDATA_I,
   input  wire logic                      HREADY_I,
   output logic      [31:0]               HRDATA_O,
   output logic                           HREADYOUT_O,
   output logic                           HRESP_O,
   // monitored agent events
   input  wire iocpc_pkg::iocpc_events_t  EVENTS_I
);

   if (CTR_W != iocpc_pkg::CTR_W || INC_W != iocpc_pkg::INC_W)
      $error("iocpc_top: widths must match the package");

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   iocpc_pkg::iocpc_regs_t  r;
   iocpc_pkg::iocpc_regs_t  next_r;
   logic [INC_W-1:0]        inc0;
   logic [INC_W-1:0]        inc1;
   logic [CTR_W-1:0]        count0;
   logic [CTR_W-1:0]        count1;
   logic                    wrap0;
   logic                    wrap1;
   logic                    addr_ok;
   logic                    wr_ctl0;
   logic                    wr_ctl1;
   logic                    clear0;
   logic                    clear1;
   logic                    ld0_lo;
   logic                    ld0_hi;
   logic                    ld1_lo;
   logic                    ld1_hi;
   logic                    sw0;
   logic                    sw1;
   logic                    en0;
   logic                    en1;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic mapped(input logic [7:0] ofs);
      return ofs == iocpc_pkg::OFS_CTL0    || ofs == iocpc_pkg::OFS_CTL1    ||
             ofs == iocpc_pkg::OFS_CTR0_LO || ofs == iocpc_pkg::OFS_CTR0_HI ||
             ofs == iocpc_pkg::OFS_CTR1_LO || ofs == iocpc_pkg::OFS_CTR1_HI ||
             ofs == iocpc_pkg::OFS_STATUS;
   endfunction

   function automatic logic [31:0] hi_word(input logic [CTR_W-1:0] c);
      logic [31:0] w;
      w = '0;
      w[CTR_W-33:0] = c[CTR_W-1:32];
      return w;
   endfunction

   function automatic logic [7:0] ev_code(input logic [31:0] ctl);
      return ctl[iocpc_pkg::CTL_EV_LSB +: 8];
   endfunction

   function automatic logic [7:0] ev_umask(input logic [31:0] ctl);
      return ctl[iocpc_pkg::CTL_UM_LSB +: 8];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // address and data phase decode

   assign addr_ok = HSEL_I & (HTRANS_I == iocpc_pkg::HTRANS_NONSEQ) & HREADY_I & (HADDR_I[31:8] == 24'h000000);
   assign wr_ctl0 = r.wr_pend & (r.wr_ofs == iocpc_pkg::OFS_CTL0);
   assign wr_ctl1 = r.wr_pend & (r.wr_ofs == iocpc_pkg::OFS_CTL1);
   assign clear0  = wr_ctl0 & HWDATA_I[iocpc_pkg::CTL_CLR_BIT];
   assign clear1  = wr_ctl1 & HWDATA_I[iocpc_pkg::CTL_CLR_BIT];
   assign ld0_lo  = r.wr_pend & (r.wr_ofs == iocpc_pkg::OFS_CTR0_LO);
   assign ld0_hi  = r.wr_pend & (r.wr_ofs == iocpc_pkg::OFS_CTR0_HI);
   assign ld1_lo  = r.wr_pend & (r.wr_ofs == iocpc_pkg::OFS_CTR1_LO);
   assign ld1_hi  = r.wr_pend & (r.wr_ofs == iocpc_pkg::OFS_CTR1_HI);
   assign sw0     = clear0 | ld0_lo | ld0_hi;
   assign sw1     = clear1 | ld1_lo | ld1_hi;
   assign en0     = r.ctl0[iocpc_pkg::CTL_EN_BIT];
   assign en1     = r.ctl1[iocpc_pkg::CTL_EN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // event selection and counters

   iocpc_event_sel u_sel0 (
      .code_i  (ev_code(r.ctl0)),
      .umask_i (ev_umask(r.ctl0)),
      .ev_i    (EVENTS_I),
      .inc_o   (inc0)
   );

   iocpc_event_sel u_sel1 (
      .code_i  (ev_code(r.ctl1)),
      .umask_i (ev_umask(r.ctl1)),
      .ev_i    (EVENTS_I),
      .inc_o   (inc1)
   );

   iocpc_counter #(
      .CTR_W (CTR_W),
      .INC_W (INC_W)
   ) u_ctr0 (
      .clk_i     (REF_CLK_I),
      .rst_i     (RESET_I),
      .en_i      (en0),
      .inc_i     (inc0),
      .clear_i   (clear0),
      .load_lo_i (ld0_lo),
      .load_hi_i (ld0_hi),
      .wdata_i   (HWDATA_I),
      .count_o   (count0),
      .wrap_o    (wrap0)
   );

   iocpc_counter #(
      .CTR_W (CTR_W),
      .INC_W (INC_W)
   ) u_ctr1 (
      .clk_i     (REF_CLK_I),
      .rst_i     (RESET_I),
      .en_i      (en1),
      .inc_i     (inc1),
      .clear_i   (clear1),
      .load_lo_i (ld1_lo),
      .load_hi_i (ld1_hi),
      .wdata_i   (HWDATA_I),
      .count_o   (count1),
      .wrap_o    (wrap1)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register state

   always_comb begin
      next_r = r;
      // data phase of a write
      if (wr_ctl0)
         next_r.ctl0 = HWDATA_I & iocpc_pkg::CTL_RW_MASK;
      if (wr_ctl1)
         next_r.ctl1 = HWDATA_I & iocpc_pkg::CTL_RW_MASK;
      // wrap flags: write one clears, a new wrap wins
      if (r.wr_pend && r.wr_ofs == iocpc_pkg::OFS_STATUS)
         next_r.wrap = r.wrap & ~HWDATA_I[1:0];
      next_r.wrap = next_r.wrap | {wrap1, wrap0};
      // address phase
      next_r.wr_pend = addr_ok & HWRITE_I & mapped(HADDR_I[7:0]);
      next_r.wr_ofs  = HADDR_I[7:0];
      next_r.rdata   = 32'h00000000;
      if (addr_ok && !HWRITE_I) begin
         unique case (HADDR_I[7:0])
            iocpc_pkg::OFS_CTL0:    next_r.rdata = next_r.ctl0;
            iocpc_pkg::OFS_CTL1:    next_r.rdata = next_r.ctl1;
            iocpc_pkg::OFS_CTR0_LO: next_r.rdata = count0[31:0];
            iocpc_pkg::OFS_CTR0_HI: next_r.rdata = hi_word(count0);
            iocpc_pkg::OFS_CTR1_LO: next_r.rdata = count1[31:0];
            iocpc_pkg::OFS_CTR1_HI: next_r.rdata = hi_word(count1);
            iocpc_pkg::OFS_STATUS:  next_r.rdata = {30'h00000000, next_r.wrap};
            default:                next_r.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         r.ctl0    <= iocpc_pkg::CTL_RST;
         r.ctl1    <= iocpc_pkg::CTL_RST;
         r.wrap    <= iocpc_pkg::WRAP_RST;
         r.wr_pend <= 1'b0;
         r.wr_ofs  <= 8'h00;
         r.rdata   <= 32'h00000000;
      end else begin
         r <= next_r;
      end
   end

   assign HRDATA_O    = r.rdata;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_ctl0_write;
      addr_ok && HWRITE_I && HADDR_I[7:0] == iocpc_pkg::OFS_CTL0 ##1 1'b1;
   endsequence

   a_ctl0_update: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      s_ctl0_write |=> r.ctl0 == ($past(HWDATA_I) & iocpc_pkg::CTL_RW_MASK))
      else $error("control word 0 not taken from write data");

   a_cycle_tick: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      en0 && ev_code(r.ctl0) == iocpc_pkg::EV_CYCLE && !sw0 |=> count0 == $past(count0) + 48'h1)
      else $error("cycle event did not add one");

   a_full_amount: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      en1 && !sw1 |=> count1 == $past(count1) + CTR_W'($past(inc1)))
      else $error("counter 1 did not add the whole amount");

   a_hold_off: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      (!en0 && !sw0) [*2] |-> $stable(count0))
      else $error("disabled counter moved");

   a_occ_sum: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl0) == iocpc_pkg::EV_WC_OCC && ev_umask(r.ctl0) == iocpc_pkg::UM_ANY
      |-> inc0 == 7'(EVENTS_I.wc_rd_occ[iocpc_pkg::SRC_ANY]) + 7'(EVENTS_I.wc_wr_occ[iocpc_pkg::SRC_ANY]))
      else $error("occupancy sum wrong");

   a_wc_source: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl1) == iocpc_pkg::EV_WC_OCC && ev_umask(r.ctl1) == iocpc_pkg::UM_SNOOP
      |-> inc1 == 7'(EVENTS_I.wc_rd_occ[iocpc_pkg::SRC_SNOOP]) + 7'(EVENTS_I.wc_wr_occ[iocpc_pkg::SRC_SNOOP]))
      else $error("snoop source not selected");

   a_ring_insert: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl0) == iocpc_pkg::EV_DR_INS + 8'h02 |-> inc0 == 7'(EVENTS_I.dr_insert[iocpc_pkg::CLS_STD]))
      else $error("standard class insert not selected");

   a_ack_alloc: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl1) == iocpc_pkg::EV_ACK |-> inc1 == 7'(EVENTS_I.ack_alloc))
      else $error("acknowledge allocation not selected");

   a_ring_full: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl0) == iocpc_pkg::EV_DR_FULL + 8'h01 |-> inc0 == 7'(EVENTS_I.dr_full[iocpc_pkg::CLS_BYPASS]))
      else $error("bypass class full not selected");

   a_ring_occ: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl1) == iocpc_pkg::EV_DR_OCC |-> inc1 == EVENTS_I.dr_occ[iocpc_pkg::CLS_RESP])
      else $error("response class occupancy not selected");

   a_outreq_occ: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl0) == iocpc_pkg::EV_OUTREQ |-> inc0 == EVENTS_I.outreq_occ)
      else $error("outbound request occupancy not selected");

   a_credit_stall: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl1) == iocpc_pkg::EV_DR_STALL |-> inc1 == 7'(EVENTS_I.dr_stall))
      else $error("data ring stall not selected");

   a_faf_occ: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      ev_code(r.ctl0) == iocpc_pkg::EV_FAF_OCC |-> inc0 == EVENTS_I.faf_occ)
      else $error("forward queue occupancy not selected");

   a_wrap_flag: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      wrap0 |=> r.wrap[0] && count0 < CTR_W'($past(inc0)))
      else $error("wrap of counter 0 not flagged");

endmodule

// [tb/iocpc_agent_model.sv]
// event source model of the monitored coherency agent pipeline
`timescale 1ns/1ps
module iocpc_agent_model #(
   parameter int BURST = 5
) (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // burst request
   input  wire logic                     start_i,
   input  wire logic [7:0]               code_i,
   input  wire logic [7:0]               umask_i,
   input  wire logic [6:0]               amt_i,
   // agent events
   output iocpc_pkg::iocpc_events_t      ev_o
);
   logic [3:0] left;
   int         src;

   ////////////////////////////////////////////////////////////////////////////
   // burst length counter
   always_ff @(posedge clk_i) begin
      if (rst_i) left <= 4'h0;
      else if (start_i) left <= 4'(BURST);
      else if (left != 4'h0) left <= left - 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // selected field carries the amount, neighbours carry noise
   always_comb begin
      ev_o = '0;
      src  = (umask_i == 8'h04) ? 2 : (umask_i == 8'h02) ? 1 : 0;
      if (left != 4'h0) begin
         ev_o.dr_occ     = {3{7'h03}};
         ev_o.outreq_occ = 7'h03;
         ev_o.faf_occ    = 7'h03;
         ev_o.wc_rd_occ  = {3{6'h05}};
         ev_o.wc_wr_occ  = {3{6'h05}};
         case (code_i)
            8'h02, 8'h03, 8'h04: ev_o.dr_insert[int'(code_i) - 2] = 1'b1;
            8'h05, 8'h06, 8'h07: ev_o.dr_full[int'(code_i) - 5] = 1'b1;
            8'h08, 8'h09, 8'h0a: ev_o.dr_occ[int'(code_i) - 8] = amt_i;
            8'h0b: ev_o.ack_alloc = 1'b1;
            8'h0c: ev_o.outreq_occ = amt_i;
            8'h0f: begin
               ev_o.wc_rd_occ[src] = amt_i[5:0];
               ev_o.wc_wr_occ[src] = amt_i[5:0];
            end
            8'h16: ev_o.faf_sent = 1'b1;
            8'h17: ev_o.faf_full = 1'b1;
            8'h18: ev_o.faf_insert = 1'b1;
            8'h19: ev_o.faf_occ = amt_i;
            8'h1a: ev_o.ad_stall = 1'b1;
            8'h1b: ev_o.dr_stall = 1'b1;
            default: ;
         endcase
      end
   end
endmodule

// [tb/tb.sv]
// self-checking bench of the coherency agent event counters
`timescale 1ns/1ps
module tb;
   logic                     ref_clk, reset, hsel, hwrite, start, hreadyout, hresp;
   logic [31:0]              haddr, hwdata, hrdata, rd, lo, hi;
   logic [1:0]               htrans;
   logic [7:0]               m_code, m_umask;
   logic [6:0]               m_amt;
   iocpc_pkg::iocpc_events_t ev;
   int                       fails, n_checks;

   iocpc_top dut (.REF_CLK_I(ref_clk), .RESET_I(reset), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
      .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
      .EVENTS_I(ev));
   iocpc_agent_model model (.clk_i(ref_clk), .rst_i(reset), .start_i(start),
      .code_i(m_code), .umask_i(m_umask), .amt_i(m_amt), .ev_o(ev));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // report and compare
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one AHB-Lite transfer, entered just after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rv);
      int   n;
      logic stuck;
      n = 0;
      hsel   <= 1'b1;
      haddr  <= {24'h0, ofs};
      htrans <= iocpc_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
      stuck = (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
      rv = hrdata;
      chk({47'h0, hresp}, 48'h0);
      if (stuck || hreadyout !== 1'b1) begin
         fails++;
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      ahb(1'b1, ofs, d, rd);
   endtask

   task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
      ahb(1'b0, ofs, 32'h0, rd);
      chk({16'h0, rd}, {16'h0, exp});
   endtask

   // model drives one burst of five cycles, then idles at zero
   task automatic burst(input logic [7:0] code, input logic [7:0] um, input logic [6:0] amt);
      m_code  <= code;
      m_umask <= um;
      m_amt   <= amt;
      start   <= 1'b1;
      @(posedge ref_clk);
      start   <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask

   task automatic run_case(input logic ctr, input logic [7:0] code, input logic [7:0] um,
                           input logic [6:0] amt, input logic en, input int per);
      wr(ctr ? iocpc_pkg::OFS_CTL1 : iocpc_pkg::OFS_CTL0, {9'h0, en, 4'h0, 1'b1, 1'b0, um, code});
      burst(code, um, amt);
      ahb(1'b0, ctr ? iocpc_pkg::OFS_CTR1_LO : iocpc_pkg::OFS_CTR0_LO, 32'h0, lo);
      ahb(1'b0, ctr ? iocpc_pkg::OFS_CTR1_HI : iocpc_pkg::OFS_CTR0_HI, 32'h0, hi);
      chk({hi[15:0], lo}, 48'(5 * per));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
      start = 1'b0; m_code = 8'h0; m_umask = 8'h0; m_amt = 7'h0; fails = 0; n_checks = 0;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      rdc(iocpc_pkg::OFS_CTL0, iocpc_pkg::CTL_RST);
      rdc(iocpc_pkg::OFS_CTR0_LO, 32'h0);
      rdc(8'h1c, 32'h0);
      wr(iocpc_pkg::OFS_CTL1, 32'hffffffff);
      rdc(iocpc_pkg::OFS_CTL1, iocpc_pkg::CTL_RW_MASK);
      run_case(1'b0, 8'h02, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b1, 8'h03, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b0, 8'h04, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b1, 8'h0b, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b0, 8'h05, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b0, 8'h06, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b0, 8'h07, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b1, 8'h08, 8'h00, 7'h7f, 1'b1, 127);
      run_case(1'b0, 8'h09, 8'h00, 7'h40, 1'b1, 64);
      run_case(1'b1, 8'h0a, 8'h00, 7'h11, 1'b1, 17);
      run_case(1'b0, 8'h0c, 8'h00, 7'h7f, 1'b1, 127);
      run_case(1'b0, 8'h0f, iocpc_pkg::UM_ANY, 7'h3f, 1'b1, 126);
      run_case(1'b1, 8'h0f, iocpc_pkg::UM_SNOOP, 7'h21, 1'b1, 66);
      run_case(1'b1, 8'h0f, iocpc_pkg::UM_MEM, 7'h0a, 1'b1, 20);
      run_case(1'b1, 8'h0f, 8'h03, 7'h3f, 1'b1, 0);
      run_case(1'b0, 8'h1a, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b1, 8'h1b, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b0, 8'h16, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b1, 8'h17, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b0, 8'h18, 8'h00, 7'h00, 1'b1, 1);
      run_case(1'b0, 8'h19, 8'h00, 7'h55, 1'b1, 85);
      run_case(1'b0, 8'h02, 8'h00, 7'h00, 1'b0, 0);
      // cycle event: two reads two cycles apart
      wr(iocpc_pkg::OFS_CTL0, 32'h00420001);
      ahb(1'b0, iocpc_pkg::OFS_CTR0_LO, 32'h0, lo);
      ahb(1'b0, iocpc_pkg::OFS_CTR0_LO, 32'h0, hi);
      chk(48'(hi - lo), 48'h2);
      // 48-bit wrap through a preset near the top
      wr(iocpc_pkg::OFS_STATUS, 32'h3);
      wr(iocpc_pkg::OFS_CTL0, 32'h00400008);
      wr(iocpc_pkg::OFS_CTR0_LO, 32'hfffffff0);
      wr(iocpc_pkg::OFS_CTR0_HI, 32'h0000ffff);
      burst(8'h08, 8'h00, 7'h7f);
      ahb(1'b0, iocpc_pkg::OFS_CTR0_LO, 32'h0, lo);
      ahb(1'b0, iocpc_pkg::OFS_CTR0_HI, 32'h0, hi);
      chk({hi[15:0], lo}, 48'h26b);
      rdc(iocpc_pkg::OFS_STATUS, 32'h1);
      wr(iocpc_pkg::OFS_STATUS, 32'h1);
      rdc(iocpc_pkg::OFS_STATUS, 32'h0);
      complete_run();
   end
endmodule
